/* File: common/udsp_defs.vh */
`ifndef UDSP_DEFS_VH
`define UDSP_DEFS_VH
// Operating modes
`define UDSP_MODE_TERMINAL 3'h0
`define UDSP_MODE_SYSCFG 3'h1
`define UDSP_MODE_CALIB 3'h2
`define UDSP_MODE_BINARY 3'h3
`define UDSP_MODE_REMOTE 3'h4
// Baud selects
`define UDSP_BAUD_300 3'h0
`define UDSP_BAUD_1200 3'h1
`define UDSP_BAUD_2400 3'h2
`define UDSP_BAUD_4800 3'h3
`define UDSP_BAUD_9600 3'h4
`define UDSP_BAUD_19200 3'h5
// Clock rate in Hz and derived bit periods
`define UDSP_CLK_HZ 250000000
`define UDSP_DIV_300 32'd833333
`define UDSP_DIV_1200 32'd208333
`define UDSP_DIV_2400 32'd104166
`define UDSP_DIV_4800 32'd52083
`define UDSP_DIV_9600 32'd26041
`define UDSP_DIV_19200 32'd13020
// Flow control characters
`define UDSP_XON 8'h11
`define UDSP_XOFF 8'h13
// Horn timing
`define UDSP_ALARM_MS 12'd500
`define UDSP_NOTICE_MS 12'd2000
`define UDSP_MS_CYCLES 250000
`define UDSP_BEEP_MS 12'd100
`endif

/* File: hdl/udsp_serial_ctrl.v */
// Contract
// - Alarm pulses horn every half second
// - Notice pulses horn every two seconds
// - Normal lamp only in normal operation
// - Every event is logged to history
// - Calibration and binary modes port two only
// - Remote monitor mode port one only
// - Ports never share one mode
// - Six selectable baud rates per port
// - Remote monitor mode forces 300 baud
// - Port one always eight data bits
// - Port two also allows seven bits
// - Resume 0x11, pause 0x13 flow characters
// - Pause received stops transmit until resume
// - Flow off ignores handshake lines
// - Reset defaults per port
// - Terminal mode emits events immediately
// - Settings commit only when save set
// - Clear-to-send equals data-set-ready
// - Data-terminal-ready input unused
`timescale 1ns/1ns
`include "udsp_defs.vh"
module udsp_serial_ctrl
#(
  parameter MS_CYCLES = `UDSP_MS_CYCLES
)
(
  input wire mclk_in,
  input wire rst_in,
  input wire alarm_in,
  input wire notice_in,
  input wire normal_in,
  input wire [7:0] status_in,
  input wire event_in,
  input wire [7:0] event_code_in,
  input wire [2:0] edit_mode1_in,
  input wire [2:0] edit_baud1_in,
  input wire edit_two_stop1_in,
  input wire edit_flow1_in,
  input wire [2:0] edit_mode2_in,
  input wire [2:0] edit_baud2_in,
  input wire edit_seven2_in,
  input wire edit_two_stop2_in,
  input wire edit_flow2_in,
  input wire setup_exit_in,
  input wire save_in,
  input wire rxd1_in,
  input wire rxd2_in,
  input wire rts2_in,
  input wire dtr2_in,
  output reg horn_out,
  output reg normal_lamp_out,
  output reg [7:0] status_lamp_out,
  output reg log_we_out,
  output reg [7:0] log_data_out,
  output reg [8:0] log_addr_out,
  output reg [2:0] mode1_out,
  output reg [2:0] mode2_out,
  output wire [2:0] baud1_out,
  output wire [2:0] baud2_out,
  output reg cfg_reject_out,
  output wire txd1_out,
  output wire txd2_out,
  output wire cts2_out,
  output wire dsr2_out,
  output wire [7:0] rx2_data_out,
  output wire rx2_valid_out,
  output wire event_drop_out
);
  reg [2:0] baud1;
  reg [2:0] baud2;
  reg two_stop1;
  reg two_stop2;
  reg seven2;
  reg flow1;
  reg flow2;
  // Commit on leaving setup only with save set; illegal combos rejected whole
  wire bad1 = edit_mode1_in == `UDSP_MODE_CALIB || edit_mode1_in == `UDSP_MODE_BINARY
    || edit_mode1_in > `UDSP_MODE_REMOTE;
  wire bad2 = edit_mode2_in == `UDSP_MODE_REMOTE || edit_mode2_in > `UDSP_MODE_REMOTE;
  wire same = edit_mode1_in == edit_mode2_in;
  wire badb = edit_baud1_in > `UDSP_BAUD_19200 || edit_baud2_in > `UDSP_BAUD_19200;
  always @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      mode1_out <= `UDSP_MODE_REMOTE;
      mode2_out <= `UDSP_MODE_TERMINAL;
      baud1 <= `UDSP_BAUD_300;
      baud2 <= `UDSP_BAUD_9600;
      two_stop1 <= 1'b0;
      two_stop2 <= 1'b0;
      seven2 <= 1'b0;
      flow1 <= 1'b0;
      flow2 <= 1'b0;
      cfg_reject_out <= 1'b0;
    end
    else
    begin
      cfg_reject_out <= 1'b0;
      if (setup_exit_in && save_in)
      begin
        if (bad1 || bad2 || same || badb)
        begin
          cfg_reject_out <= 1'b1;
        end
        else
        begin
          mode1_out <= edit_mode1_in;
          mode2_out <= edit_mode2_in;
          baud1 <= edit_baud1_in;
          baud2 <= edit_baud2_in;
          two_stop1 <= edit_two_stop1_in;
          two_stop2 <= edit_two_stop2_in;
          seven2 <= edit_seven2_in;
          flow1 <= edit_flow1_in;
          flow2 <= edit_flow2_in;
        end
      end
    end
  end
  assign baud1_out = (mode1_out == `UDSP_MODE_REMOTE) ? `UDSP_BAUD_300 : baud1;
  assign baud2_out = baud2;
  // Event path: log always, and send to terminal-mode port and to port one in remote mode
  reg [7:0] ev_byte;
  reg ev_pend1;
  reg ev_pend2;
  wire rdy1;
  wire rdy2;
  wire send1 = mode1_out == `UDSP_MODE_TERMINAL || mode1_out == `UDSP_MODE_REMOTE;
  wire send2 = mode2_out == `UDSP_MODE_TERMINAL;
  // One holding byte shared by both ports; a new event while one is still pending overwrites the pending byte, and the drop is flagged
  assign event_drop_out = event_in && ((ev_pend1 && send1) || (ev_pend2 && send2));
  always @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ev_byte <= 8'h00;
      ev_pend1 <= 1'b0;
      ev_pend2 <= 1'b0;
      log_we_out <= 1'b0;
      log_data_out <= 8'h00;
      log_addr_out <= 9'h000;
    end
    else
    begin
      log_we_out <= event_in;
      if (event_in)
      begin
        log_data_out <= event_code_in;
        log_addr_out <= log_addr_out + 9'h001;
        ev_byte <= event_code_in;
      end
      if (event_in && send1)
      begin
        ev_pend1 <= 1'b1;
      end
      else if (rdy1)
      begin
        ev_pend1 <= 1'b0;
      end
      if (event_in && send2)
      begin
        ev_pend2 <= 1'b1;
      end
      else if (rdy2)
      begin
        ev_pend2 <= 1'b0;
      end
    end
  end
  udsp_uart_port u_port1
  (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .baud_in(baud1_out),
    .seven_bit_in(1'b0),
    .two_stop_in(two_stop1),
    .flow_en_in(flow1),
    .tx_data_in(ev_byte),
    .tx_valid_in(ev_pend1),
    .tx_ready_out(rdy1),
    .txd_out(txd1_out),
    .rxd_in(rxd1_in),
    .rx_data_out(),
    .rx_valid_out(),
    .paused_out()
  );
  udsp_uart_port u_port2
  (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .baud_in(baud2_out),
    .seven_bit_in(seven2),
    .two_stop_in(two_stop2),
    .flow_en_in(flow2),
    .tx_data_in(ev_byte),
    .tx_valid_in(ev_pend2),
    .tx_ready_out(rdy2),
    .txd_out(txd2_out),
    .rxd_in(rxd2_in),
    .rx_data_out(rx2_data_out),
    .rx_valid_out(rx2_valid_out),
    .paused_out()
  );
  // Handshake lines are not used; rts2 and dtr2 stay unread
  assign cts2_out = 1'b1;
  assign dsr2_out = cts2_out;
  // Horn: millisecond tick, then period counter
  reg [31:0] ms_cnt;
  reg [11:0] per_cnt;
  wire ms_tick = ms_cnt == MS_CYCLES - 1;
  wire [11:0] period = alarm_in ? `UDSP_ALARM_MS : `UDSP_NOTICE_MS;
  always @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ms_cnt <= 32'h0;
      per_cnt <= 12'h000;
      horn_out <= 1'b0;
      normal_lamp_out <= 1'b0;
      status_lamp_out <= 8'h00;
    end
    else
    begin
      ms_cnt <= ms_tick ? 32'h0 : ms_cnt + 32'h1;
      if (!alarm_in && !notice_in)
      begin
        per_cnt <= 12'h000;
        horn_out <= 1'b0;
      end
      else if (ms_tick)
      begin
        per_cnt <= (per_cnt >= period - 12'h001) ? 12'h000 : per_cnt + 12'h001;
        horn_out <= per_cnt < `UDSP_BEEP_MS;
      end
      // Other lamps only when not normal
      normal_lamp_out <= normal_in && !alarm_in && !notice_in;
      status_lamp_out <= normal_lamp_out ? 8'h00 : status_in;
    end
  end
endmodule

/* File: hdl/udsp_uart_port.v */
`timescale 1ns/1ns
`include "udsp_defs.vh"
module udsp_uart_port
(
  input wire mclk_in,
  input wire rst_in,
  input wire [2:0] baud_in,
  input wire seven_bit_in,
  input wire two_stop_in,
  input wire flow_en_in,
  input wire [7:0] tx_data_in,
  input wire tx_valid_in,
  output wire tx_ready_out,
  output reg txd_out,
  input wire rxd_in,
  output reg [7:0] rx_data_out,
  output reg rx_valid_out,
  output reg paused_out
);
  function [31:0] udsp_div;
    input [2:0] sel;
    begin
      case (sel)
        `UDSP_BAUD_300: udsp_div = `UDSP_DIV_300;
        `UDSP_BAUD_1200: udsp_div = `UDSP_DIV_1200;
        `UDSP_BAUD_2400: udsp_div = `UDSP_DIV_2400;
        `UDSP_BAUD_4800: udsp_div = `UDSP_DIV_4800;
        `UDSP_BAUD_9600: udsp_div = `UDSP_DIV_9600;
        default: udsp_div = `UDSP_DIV_19200;
      endcase
    end
  endfunction
  wire [31:0] div = udsp_div(baud_in);
  wire [3:0] nbits = seven_bit_in ? 4'h7 : 4'h8;
  // Transmitter: start, data lsb first, stop bits
  reg tx_busy;
  reg [31:0] tx_cnt;
  reg [3:0] tx_bit;
  reg [9:0] tx_shift;
  reg [3:0] tx_total;
  assign tx_ready_out = !tx_busy && !paused_out;
  always @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tx_busy <= 1'b0;
      tx_cnt <= 32'h0;
      tx_bit <= 4'h0;
      tx_shift <= 10'h3ff;
      tx_total <= 4'h0;
      txd_out <= 1'b1;
    end
    else if (!tx_busy)
    begin
      txd_out <= 1'b1;
      if (tx_valid_in && tx_ready_out)
      begin
        tx_busy <= 1'b1;
        tx_cnt <= 32'h0;
        tx_bit <= 4'h0;
        tx_shift <= {2'b11, tx_data_in};
        tx_total <= nbits + (two_stop_in ? 4'h3 : 4'h2);
        txd_out <= 1'b0;
      end
    end
    else if (tx_cnt == div - 32'h1)
    begin
      tx_cnt <= 32'h0;
      tx_bit <= tx_bit + 4'h1;
      if (tx_bit + 4'h1 == tx_total)
      begin
        tx_busy <= 1'b0;
        txd_out <= 1'b1;
      end
      else
      begin
        // Stop bits are a constant one once past the data bits
        txd_out <= (tx_bit + 4'h1 > nbits) ? 1'b1 : tx_shift[tx_bit[2:0]];
      end
    end
    else
    begin
      tx_cnt <= tx_cnt + 32'h1;
    end
  end
  // Receiver samples mid-bit; no parity expected
  reg rx_busy;
  reg [31:0] rx_cnt;
  reg [3:0] rx_bit;
  reg [7:0] rx_shift;
  always @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rx_busy <= 1'b0;
      rx_cnt <= 32'h0;
      rx_bit <= 4'h0;
      rx_shift <= 8'h00;
      rx_data_out <= 8'h00;
      rx_valid_out <= 1'b0;
      paused_out <= 1'b0;
    end
    else
    begin
      rx_valid_out <= 1'b0;
      if (!flow_en_in)
      begin
        paused_out <= 1'b0;
      end
      if (!rx_busy)
      begin
        if (!rxd_in)
        begin
          rx_busy <= 1'b1;
          rx_cnt <= {1'b0, div[31:1]};
          rx_bit <= 4'h0;
        end
      end
      else if (rx_cnt == div - 32'h1)
      begin
        rx_cnt <= 32'h0;
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0 && rxd_in)
        begin
          rx_busy <= 1'b0;
        end
        else if (rx_bit == nbits + 4'h1)
        begin
          rx_busy <= 1'b0;
          rx_data_out <= seven_bit_in ? {1'b0, rx_shift[7:1]} : rx_shift;
          rx_valid_out <= rxd_in;
          if (rxd_in && flow_en_in)
          begin
            if ((seven_bit_in ? {1'b0, rx_shift[7:1]} : rx_shift) == `UDSP_XOFF)
            begin
              paused_out <= 1'b1;
            end
            else if ((seven_bit_in ? {1'b0, rx_shift[7:1]} : rx_shift) == `UDSP_XON)
            begin
              paused_out <= 1'b0;
            end
          end
        end
        else if (rx_bit != 4'h0)
        begin
          rx_shift <= {rxd_in, rx_shift[7:1]};
        end
      end
      else
      begin
        rx_cnt <= rx_cnt + 32'h1;
      end
    end
  end
endmodule

/* File: test/tb_top.sv */
`timescale 1ns/1ns
`include "udsp_defs.vh"
module tb_top;
  localparam int MS = 4;
  localparam int DIV = `UDSP_DIV_19200;
  logic mclk_in, rst_in, alarm_in, notice_in, normal_in, event_in, setup_exit_in, save_in;
  logic edit_two_stop1_in, edit_flow1_in, edit_seven2_in, edit_two_stop2_in, edit_flow2_in;
  logic rxd1_in, rxd2_in, rts2_in, dtr2_in, horn_out, normal_lamp_out, log_we_out;
  logic cfg_reject_out, txd1_out, txd2_out, cts2_out, dsr2_out, rx2_valid_out, event_drop_out;
  logic [7:0] status_in, event_code_in, status_lamp_out, log_data_out, rx2_data_out;
  logic [2:0] edit_mode1_in, edit_baud1_in, edit_mode2_in, edit_baud2_in;
  logic [2:0] mode1_out, mode2_out, baud1_out, baud2_out;
  logic [8:0] log_addr_out;
  logic [1:0] seen;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int p;
  // Mode1, mode2, save; then expected mode1, mode2, baud1, reject
  logic [16:0] rows [9] = '{
    {3'h0, 3'h1, 1'h1, 3'h0, 3'h1, 3'h5, 1'h0}, {3'h1, 3'h1, 1'h1, 3'h0, 3'h1, 3'h5, 1'h1},
    {3'h2, 3'h0, 1'h1, 3'h0, 3'h1, 3'h5, 1'h1}, {3'h0, 3'h4, 1'h1, 3'h0, 3'h1, 3'h5, 1'h1},
    {3'h3, 3'h2, 1'h1, 3'h0, 3'h1, 3'h5, 1'h1}, {3'h4, 3'h3, 1'h0, 3'h0, 3'h1, 3'h5, 1'h0},
    {3'h4, 3'h2, 1'h1, 3'h4, 3'h2, 3'h0, 1'h0}, {3'h4, 3'h3, 1'h1, 3'h4, 3'h3, 3'h0, 1'h0},
    {3'h4, 3'h0, 1'h1, 3'h4, 3'h0, 3'h0, 1'h0}};
  udsp_serial_ctrl #(.MS_CYCLES(MS)) dut (.mclk_in, .rst_in, .alarm_in, .notice_in,
    .normal_in, .status_in, .event_in, .event_code_in, .edit_mode1_in, .edit_baud1_in,
    .edit_two_stop1_in, .edit_flow1_in, .edit_mode2_in, .edit_baud2_in, .edit_seven2_in,
    .edit_two_stop2_in, .edit_flow2_in, .setup_exit_in, .save_in, .rxd1_in, .rxd2_in,
    .rts2_in, .dtr2_in, .horn_out, .normal_lamp_out, .status_lamp_out, .log_we_out,
    .log_data_out, .log_addr_out, .mode1_out, .mode2_out, .baud1_out, .baud2_out,
    .cfg_reject_out, .txd1_out, .txd2_out, .cts2_out, .dsr2_out, .rx2_data_out,
    .rx2_valid_out, .event_drop_out);
  udsp_term_model #(.DIV(DIV)) term (.mclk_in, .txd_in(txd2_out), .rxd_out(rxd2_in),
    .rts_out(rts2_in), .dtr_out(dtr2_in), .seen_out(seen));
  initial
  begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end
  task step;
    @(posedge mclk_in);
    #1;
  endtask
  task automatic check(input logic [15:0] seen_v, input logic [15:0] exp_v);
    comparisons++;
    if (seen_v !== exp_v)
    begin
      n_errors++;
      $display("FAIL at %0t seen %h expected %h", $time, seen_v, exp_v);
    end
  endtask
  task complete_run;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Rise to rise, skipping any beep already under way
  task automatic horn_period(output int n);
    n = 0;
    while (horn_out === 1'b1) step;
    while (horn_out !== 1'b1) step;
    while (horn_out === 1'b1)
    begin
      step;
      n++;
    end
    while (horn_out !== 1'b1)
    begin
      step;
      n++;
    end
  endtask
  always @(posedge mclk_in)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      n_errors++;
      complete_run;
    end
  end
  initial
  begin
    {alarm_in, notice_in, normal_in, event_in, setup_exit_in, save_in, rxd1_in} = 7'h01;
    {edit_two_stop1_in, edit_flow1_in, edit_seven2_in, edit_two_stop2_in, edit_flow2_in} = 5'h00;
    {status_in, event_code_in} = 16'h0000;
    {edit_mode1_in, edit_baud1_in, edit_mode2_in, edit_baud2_in} = 12'h965;
    rst_in = 1'b1;
    repeat (8) @(posedge mclk_in);
    #1 rst_in = 1'b0;
    for (int i = 0; i < 9; i++)
    begin
      {edit_mode1_in, edit_mode2_in, save_in} = rows[i][16:10];
      setup_exit_in = 1'b1;
      step;
      check(mode1_out, rows[i][9:7]);
      check(mode2_out, rows[i][6:4]);
      check(baud1_out, rows[i][3:1]);
      check(baud2_out, 3'h5);
      check(cfg_reject_out, rows[i][0]);
      setup_exit_in = 1'b0;
      step;
    end
    event_code_in = 8'ha5;
    event_in = 1'b1;
    step;
    check(log_we_out, 1'b1);
    check(log_data_out, 8'ha5);
    check(log_addr_out, 9'h001);
    event_in = 1'b0;
    step;
    step;
    check(txd2_out, 1'b0);
    repeat (20) step;
    // Port two busy: first event waits, a second one while it waits overwrites it and raises the drop flag
    event_in = 1'b1;
    #1 check(event_drop_out, 1'b0);
    step;
    check(log_we_out, 1'b1);
    check(event_drop_out, 1'b1);
    step;
    event_in = 1'b0;
    check(log_addr_out, 9'h003);
    repeat (2 * DIV) step;
    check(seen, 2'h2);
    alarm_in = 1'b1;
    horn_period(p);
    check(p, `UDSP_ALARM_MS * MS);
    alarm_in = 1'b0;
    notice_in = 1'b1;
    horn_period(p);
    check(p, `UDSP_NOTICE_MS * MS);
    notice_in = 1'b0;
    normal_in = 1'b1;
    repeat (500) step;
    check(horn_out, 1'b0);
    check({normal_lamp_out, status_lamp_out}, 9'h100);
    {normal_in, status_in} = 9'h024;
    repeat (2) step;
    check({normal_lamp_out, status_lamp_out}, 9'h024);
    rst_in = 1'b1;
    #1;
    check({mode1_out, baud1_out, mode2_out, baud2_out}, 12'h804);
    check({txd1_out, txd2_out, horn_out}, 3'h6);
    step;
    rst_in = 1'b0;
    step;
    complete_run;
  end
endmodule
bind udsp_serial_ctrl udsp_serial_ctrl_assertions chk (.mclk_in, .rst_in, .event_in,
  .setup_exit_in, .save_in, .edit_mode1_in, .edit_mode2_in, .log_we_out, .mode1_out,
  .mode2_out, .baud1_out, .baud2_out, .cfg_reject_out, .cts2_out, .dsr2_out);

/* File: test/udsp_serial_ctrl_assertions.sv */
`timescale 1ns/1ns
module udsp_serial_ctrl_assertions
(
  input logic mclk_in,
  input logic rst_in,
  input logic event_in,
  input logic setup_exit_in,
  input logic save_in,
  input logic [2:0] edit_mode1_in,
  input logic [2:0] edit_mode2_in,
  input logic log_we_out,
  input logic [2:0] mode1_out,
  input logic [2:0] mode2_out,
  input logic [2:0] baud1_out,
  input logic [2:0] baud2_out,
  input logic cfg_reject_out,
  input logic cts2_out,
  input logic dsr2_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  sequence bad_commit;
    setup_exit_in && save_in && (edit_mode1_in == edit_mode2_in || edit_mode1_in == 3'h2 ||
      edit_mode1_in == 3'h3 || edit_mode2_in == 3'h4);
  endsequence
  sequence skip_commit;
    setup_exit_in && !save_in;
  endsequence
  pair_tied_a: assert property (cts2_out == dsr2_out)
    else $error("cts and dsr differ");
  modes_differ_a: assert property (mode1_out != mode2_out)
    else $error("ports share a mode");
  port1_modes_a: assert property (mode1_out != 3'h2 && mode1_out != 3'h3)
    else $error("port one in a port two mode");
  port2_modes_a: assert property (mode2_out != 3'h4)
    else $error("port two in remote mode");
  remote_rate_a: assert property (mode1_out == 3'h4 |-> baud1_out == 3'h0)
    else $error("remote mode not at slowest rate");
  rate_range_a: assert property (baud1_out <= 3'h5 && baud2_out <= 3'h5)
    else $error("rate select out of range");
  history_write_a: assert property (event_in |=> log_we_out)
    else $error("event not written to history");
  reject_commit_a: assert property (bad_commit |=> cfg_reject_out && $stable(mode1_out)
    && $stable(mode2_out)) else $error("bad setting not refused");
  no_save_a: assert property (skip_commit |=> !cfg_reject_out && $stable(mode1_out)
    && $stable(mode2_out)) else $error("settings changed without save");
endmodule

/* File: test/udsp_term_model.sv */
`timescale 1ns/1ns
module udsp_term_model
#(
  parameter int DIV = 13020
)
(
  input wire mclk_in,
  input wire txd_in,
  output logic rxd_out,
  output logic rts_out,
  output logic dtr_out,
  output logic [1:0] seen_out
);
  // Sends nothing, so never talks over a pause; idle line, no parity
  initial
  begin
    rxd_out = 1'b1;
    rts_out = 1'b0;
    seen_out = 2'h3;
  end
  // Handshake lines wiggle; with flow off the port must not care
  always @(posedge mclk_in)
  begin
    rts_out <= ~rts_out;
    dtr_out <= rts_out;
  end
  // Mid-cell samples of start bit and first data bit at the fast rate
  always
  begin
    @(negedge txd_in);
    repeat (DIV / 2) @(posedge mclk_in);
    seen_out[0] = txd_in;
    repeat (DIV) @(posedge mclk_in);
    seen_out[1] = txd_in;
    repeat (DIV * 9) @(posedge mclk_in);
  end
endmodule
